// >>> hdl/lgt_pkg.sv
// Package with register indices, field layouts, reset values and gain constants of the line gain/threshold bank
package lgt_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [5:0] IDX_RECEIVE_GAIN       = 6'h1a;
  localparam logic [5:0] IDX_TRANSMIT_GAIN      = 6'h1b;
  localparam logic [5:0] IDX_LOOP_UPPER         = 6'h1c;
  localparam logic [5:0] IDX_RING_TRIP          = 6'h1d;
  localparam logic [5:0] IDX_CM_LOW             = 6'h1e;
  localparam logic [5:0] IDX_CM_HIGH            = 6'h1f;
  localparam logic [5:0] IDX_POWER_ALARM_A      = 6'h20;
  localparam logic [5:0] IDX_POWER_ALARM_B      = 6'h21;
  localparam logic [5:0] IDX_POWER_ALARM_C      = 6'h22;
  localparam logic [5:0] IDX_LOOP_FILTER_COEFF  = 6'h23;
  localparam logic [5:0] IDX_RING_FILTER_COEFF  = 6'h24;
  localparam logic [5:0] IDX_THERMAL_POLE_A     = 6'h25;
  localparam logic [5:0] IDX_THERMAL_POLE_B     = 6'h26;
  localparam logic [5:0] IDX_THERMAL_POLE_C     = 6'h27;
  localparam logic [5:0] IDX_RINGING_BIAS       = 6'h28;
  localparam logic [5:0] IDX_OVERHEAD_VOLTAGE   = 6'h29;
  localparam logic [5:0] IDX_RESERVED           = 6'h2a;
  localparam logic [5:0] IDX_LOOP_LOWER         = 6'h2b;
  localparam logic [5:0] IDX_HYST_CTRL          = 6'h30;
  localparam logic [5:0] IDX_DETECT_STATUS      = 6'h31;
  localparam logic [5:0] IDX_BANK_FIRST         = 6'h1a;
  localparam logic [5:0] IDX_BANK_LAST          = 6'h2b;

  // ==========================================================================
  // Field layouts
  // ==========================================================================
  localparam int REG_W          = 16;
  localparam int GAIN_W         = 12;
  localparam int GAIN_LSB       = 4;
  localparam int THR_W          = 6;
  localparam int LOOP_UPPER_LSB = 9;
  localparam int RING_TRIP_LSB  = 7;
  localparam int CM_LSB         = 5;
  localparam int LOOP_LOWER_LSB = 10;
  localparam int HYST_EN_BIT    = 0;
  localparam int STAT_LOOP_BIT  = 0;
  localparam int STAT_RING_BIT  = 1;
  localparam int STAT_WIDE_BIT  = 2;

  // ==========================================================================
  // Reset values and gain encoding
  // ==========================================================================
  localparam logic [15:0] BANK_RESET      = 16'h0000;
  localparam logic [15:0] HYST_RESET      = 16'h0000;
  localparam logic [11:0] GAIN_MUTE       = 12'h000;
  localparam logic [11:0] GAIN_UNITY      = 12'h400;
  localparam logic [11:0] GAIN_MAX        = 12'h7ff;
  localparam int          GAIN_FRAC_BITS  = 10;

  typedef enum logic [1:0] {
    LGT_ST_IDLE   = 2'b01,
    LGT_ST_ACCESS = 2'b10
  } lgt_bus_state_e;

endpackage

// >>> hdl/lgt_gain_path.sv
// Saturating two's-complement gain stage for one voice path
module lgt_gain_path #(
  parameter int SAMPLE_W = 16,
  parameter int GAIN_W   = lgt_pkg::GAIN_W,
  parameter int FRAC     = lgt_pkg::GAIN_FRAC_BITS
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic signed [SAMPLE_W-1:0] sample_in,
  input  wire logic                       sample_in_valid,
  input  wire logic        [GAIN_W-1:0]   gain,
  output logic signed      [SAMPLE_W-1:0] sample_out,
  output logic                            sample_out_valid
);

  localparam int PROD_W = SAMPLE_W + GAIN_W;

  // ==========================================================================
  // Arithmetic
  // ==========================================================================
  // Clip instead of wrap, so a hot gain never flips the sign of a loud sample
  function automatic logic signed [SAMPLE_W-1:0] saturate(input logic signed [PROD_W-1:0] v);
    logic signed [PROD_W-1:0] hi;
    logic signed [PROD_W-1:0] lo;
    hi = PROD_W'({1'b0, {(SAMPLE_W-1){1'b1}}});
    lo = -hi - PROD_W'(1);
    if (v > hi)
      saturate = hi[SAMPLE_W-1:0];
    else if (v < lo)
      saturate = lo[SAMPLE_W-1:0];
    else
      saturate = v[SAMPLE_W-1:0];
  endfunction

  logic signed [PROD_W-1:0] product;
  logic signed [PROD_W-1:0] scaled;

  assign product = PROD_W'(sample_in) * PROD_W'($signed(gain));
  assign scaled  = product >>> FRAC;

  // ==========================================================================
  // Output register
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_out       <= '0;
      sample_out_valid <= 1'b0;
    end
    else
    begin
      sample_out_valid <= sample_in_valid;
      if (sample_in_valid)
        sample_out <= saturate(scaled);
    end
  end

endmodule // lgt_gain_path

// >>> hdl/lgt_line_regs.sv
// Line gain and linefeed threshold register bank with its APB slave and detectors
//
// Notes on behaviour
// - Register contents carry no guaranteed meaning after reset until software writes them.
// - Every stored value is used as a two's-complement number; the code does so for the gains only, thresholds compare unsigned.
// - Each receive sample is multiplied by the 12-bit receive gain, 0x000 mutes, 0x400 is unity, 0x7ff about +6 dB.
// - Each transmit sample is multiplied by the 12-bit transmit gain with the same encoding as receive.
// - Loop current is compared with the 6-bit loop closure threshold in 1.27 mA steps up to 80 mA.
// - With hysteresis enabled by bit 0 of the hysteresis control, the upper threshold bounds the window above.
// - With hysteresis enabled, a separate 6-bit lower threshold bounds the window below.
// - While ringing, the ring trip threshold is the detection level for ring trip.
// - Common-mode voltage below the negative threshold (0.375 V steps) selects the wider linefeed bandwidth.
// - Common-mode voltage above the positive threshold (0.375 V steps) also selects the wider bandwidth.
//
// Implementation choice: register access over APB.
module lgt_line_regs #(
  parameter int SAMPLE_W = 16,
  parameter int CM_W     = 8
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic signed [SAMPLE_W-1:0] rx_sample_in,
  input  wire logic                       rx_sample_in_valid,
  output logic signed      [SAMPLE_W-1:0] rx_sample_out,
  output logic                            rx_sample_out_valid,
  input  wire logic signed [SAMPLE_W-1:0] tx_sample_in,
  input  wire logic                       tx_sample_in_valid,
  output logic signed      [SAMPLE_W-1:0] tx_sample_out,
  output logic                            tx_sample_out_valid,
  input  wire logic [5:0]                 loop_current_code,
  input  wire logic                       ringing_active,
  input  wire logic [5:0]                 ring_current_code,
  input  wire logic signed [CM_W-1:0]     cm_voltage_code,
  output logic                            loop_closed,
  output logic                            ring_trip,
  output logic                            wide_bandwidth
);

  localparam int THR_W = lgt_pkg::THR_W;

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  function automatic logic bank_hit(input logic [5:0] idx);
    bank_hit = (idx >= lgt_pkg::IDX_BANK_FIRST) && (idx <= lgt_pkg::IDX_BANK_LAST);
  endfunction

  function automatic logic mapped(input logic [5:0] idx);
    mapped = bank_hit(idx) || (idx == lgt_pkg::IDX_HYST_CTRL) || (idx == lgt_pkg::IDX_DETECT_STATUS);
  endfunction

  // Lane merge: only the two low byte lanes reach the 16-bit registers
  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [31:0] wd, input logic [3:0] st);
    merge[7:0]  = st[0] ? wd[7:0]  : old_v[7:0];
    merge[15:8] = st[1] ? wd[15:8] : old_v[15:8];
  endfunction

  function automatic logic [THR_W-1:0] thr(input logic [15:0] v, input int lsb);
    thr = THR_W'(v >> lsb);
  endfunction

  // ==========================================================================
  // APB slave
  // ==========================================================================
  lgt_pkg::lgt_bus_state_e state_reg;
  logic [5:0]              idx;
  logic                    setup;
  logic                    wr_commit;

  assign idx       = paddr[7:2];
  assign setup     = psel && !penable;
  // Zero-wait access: pready rises for the first access cycle, so the write lands there
  assign wr_commit = psel && penable && pwrite && pready && (state_reg == lgt_pkg::LGT_ST_ACCESS)
                  && mapped(idx) && !pslverr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= lgt_pkg::LGT_ST_IDLE;
    else
    begin
      case (state_reg)
        lgt_pkg::LGT_ST_IDLE:
        begin
          if (setup)
            state_reg <= lgt_pkg::LGT_ST_ACCESS;
        end
        lgt_pkg::LGT_ST_ACCESS:
        begin
          if (setup)
            state_reg <= lgt_pkg::LGT_ST_ACCESS;
          else
            state_reg <= lgt_pkg::LGT_ST_IDLE;
        end
        default:
          state_reg <= lgt_pkg::LGT_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !mapped(idx);
    end
  end

  // ==========================================================================
  // Register storage
  // ==========================================================================
  // Reset to zero only for a defined state; software must still program every entry but the reserved one
  logic [15:0] bank_reg [int'(lgt_pkg::IDX_BANK_FIRST):int'(lgt_pkg::IDX_BANK_LAST)];
  logic [15:0] hyst_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = int'(lgt_pkg::IDX_BANK_FIRST); i <= int'(lgt_pkg::IDX_BANK_LAST); i++)
        bank_reg[i] <= lgt_pkg::BANK_RESET;
    end
    else if (wr_commit && bank_hit(idx) && (idx != lgt_pkg::IDX_RESERVED))
      bank_reg[idx] <= merge(bank_reg[idx], pwdata, pstrb);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hyst_reg <= lgt_pkg::HYST_RESET;
    else if (wr_commit && (idx == lgt_pkg::IDX_HYST_CTRL))
      hyst_reg <= merge(hyst_reg, pwdata, pstrb);
  end

  // ==========================================================================
  // Field extraction
  // ==========================================================================
  logic [lgt_pkg::GAIN_W-1:0] rx_gain;
  logic [lgt_pkg::GAIN_W-1:0] tx_gain;
  logic [THR_W-1:0]           loop_upper;
  logic [THR_W-1:0]           loop_lower;
  logic [THR_W-1:0]           ring_thr;
  logic [THR_W-1:0]           cm_low;
  logic [THR_W-1:0]           cm_high;
  logic                       hyst_en;

  assign rx_gain    = lgt_pkg::GAIN_W'(bank_reg[int'(lgt_pkg::IDX_RECEIVE_GAIN)] >> lgt_pkg::GAIN_LSB);
  assign tx_gain    = lgt_pkg::GAIN_W'(bank_reg[int'(lgt_pkg::IDX_TRANSMIT_GAIN)] >> lgt_pkg::GAIN_LSB);
  assign loop_upper = thr(bank_reg[int'(lgt_pkg::IDX_LOOP_UPPER)], lgt_pkg::LOOP_UPPER_LSB);
  assign loop_lower = thr(bank_reg[int'(lgt_pkg::IDX_LOOP_LOWER)], lgt_pkg::LOOP_LOWER_LSB);
  assign ring_thr   = thr(bank_reg[int'(lgt_pkg::IDX_RING_TRIP)], lgt_pkg::RING_TRIP_LSB);
  assign cm_low     = thr(bank_reg[int'(lgt_pkg::IDX_CM_LOW)], lgt_pkg::CM_LSB);
  assign cm_high    = thr(bank_reg[int'(lgt_pkg::IDX_CM_HIGH)], lgt_pkg::CM_LSB);
  assign hyst_en    = hyst_reg[lgt_pkg::HYST_EN_BIT];

  // ==========================================================================
  // Voice path gain
  // ==========================================================================
  lgt_gain_path #(
    .SAMPLE_W (SAMPLE_W)
  ) u_rx_gain (
    .pclk             (pclk),
    .presetn          (presetn),
    .sample_in        (rx_sample_in),
    .sample_in_valid  (rx_sample_in_valid),
    .gain             (rx_gain),
    .sample_out       (rx_sample_out),
    .sample_out_valid (rx_sample_out_valid)
  );

  lgt_gain_path #(
    .SAMPLE_W (SAMPLE_W)
  ) u_tx_gain (
    .pclk             (pclk),
    .presetn          (presetn),
    .sample_in        (tx_sample_in),
    .sample_in_valid  (tx_sample_in_valid),
    .gain             (tx_gain),
    .sample_out       (tx_sample_out),
    .sample_out_valid (tx_sample_out_valid)
  );

  // ==========================================================================
  // Loop closure detector
  // ==========================================================================
  // A lower bound above the upper one leaves the window empty; the detector then follows the upper bound alone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      loop_closed <= 1'b0;
    else if (!hyst_en)
      loop_closed <= (loop_current_code > loop_upper);
    else if (loop_current_code > loop_upper)
      loop_closed <= 1'b1;
    else if (loop_current_code < loop_lower)
      loop_closed <= 1'b0;
  end

  // ==========================================================================
  // Ring trip detector
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ring_trip <= 1'b0;
    else
      ring_trip <= ringing_active && (ring_current_code > ring_thr);
  end

  // ==========================================================================
  // Common-mode speed-up
  // ==========================================================================
  logic signed [CM_W-1:0] cm_neg_limit;
  logic signed [CM_W-1:0] cm_pos_limit;

  assign cm_pos_limit = $signed(CM_W'(cm_high));
  assign cm_neg_limit = -$signed(CM_W'(cm_low));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wide_bandwidth <= 1'b0;
    else
      wide_bandwidth <= (cm_voltage_code < cm_neg_limit)
                     || (cm_voltage_code > cm_pos_limit);
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  logic [15:0] rd_value;

  always_comb
  begin
    rd_value = 16'h0000;
    if (bank_hit(idx) && (idx != lgt_pkg::IDX_RESERVED))
      rd_value = bank_reg[idx];
    else if (idx == lgt_pkg::IDX_HYST_CTRL)
      rd_value = hyst_reg;
    else if (idx == lgt_pkg::IDX_DETECT_STATUS)
    begin
      rd_value[lgt_pkg::STAT_LOOP_BIT] = loop_closed;
      rd_value[lgt_pkg::STAT_RING_BIT] = ring_trip;
      rd_value[lgt_pkg::STAT_WIDE_BIT] = wide_bandwidth;
    end
  end

  // Read data is captured in the setup cycle and stands until the next setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup)
      prdata <= (!pwrite) ? {16'h0000, rd_value} : 32'h0000_0000;
  end

endmodule // lgt_line_regs

// >>> testbench/lgt_line_regs_monitor.sv
// Checker module watching the ports of the line gain and threshold bank
module lgt_line_regs_monitor #(
  parameter int SAMPLE_W = 16,
  parameter int CM_W     = 8
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic signed [SAMPLE_W-1:0] rx_sample_in,
  input wire logic                       rx_sample_in_valid,
  input wire logic signed [SAMPLE_W-1:0] rx_sample_out,
  input wire logic                       rx_sample_out_valid,
  input wire logic signed [SAMPLE_W-1:0] tx_sample_in,
  input wire logic                       tx_sample_in_valid,
  input wire logic signed [SAMPLE_W-1:0] tx_sample_out,
  input wire logic                       tx_sample_out_valid,
  input wire logic [5:0]                 loop_current_code,
  input wire logic                       ringing_active,
  input wire logic [5:0]                 ring_current_code,
  input wire logic signed [CM_W-1:0]     cm_voltage_code,
  input wire logic                       loop_closed,
  input wire logic                       ring_trip,
  input wire logic                       wide_bandwidth
);
  logic [5:0] idx;
  logic       mapped;
  assign idx = paddr[7:2];
  assign mapped = (idx >= lgt_pkg::IDX_BANK_FIRST && idx <= lgt_pkg::IDX_BANK_LAST) ||
                  idx == lgt_pkg::IDX_HYST_CTRL || idx == lgt_pkg::IDX_DETECT_STATUS;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Bus answers
  // ==========================================================================
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_beat: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr disagrees with address map");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  // ==========================================================================
  // Data paths and detectors
  // ==========================================================================
  a_rx_valid_delay: assert property (1'b1 |=> rx_sample_out_valid == $past(rx_sample_in_valid))
    else $error("rx valid not delayed by one");
  a_tx_valid_delay: assert property (1'b1 |=> tx_sample_out_valid == $past(tx_sample_in_valid))
    else $error("tx valid not delayed by one");
  a_ring_needs_ring: assert property (!ringing_active |=> !ring_trip)
    else $error("ring trip outside ringing");
  a_wide_cm_zero: assert property (cm_voltage_code == '0 |=> !wide_bandwidth)
    else $error("wide bandwidth with zero common mode");
  cover property (pready && pslverr);
  cover property (loop_closed);
  cover property (ring_trip);
  cover property (wide_bandwidth);
endmodule // lgt_line_regs_monitor

// >>> testbench/lgt_line_regs_tb_top.sv
// Self-checking bench for the line gain and threshold register bank
module lgt_line_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, seed = 32'h6238;
  logic [3:0] pstrb = '0;
  logic signed [15:0] rx_in = '0, tx_in = '0, rx_out, tx_out, smp [3];
  logic rx_iv = 0, tx_iv = 0, rx_ov, tx_ov, ringing = 0, loop_closed, ring_trip, wide_bandwidth;
  logic [5:0] loop_cur = '0, ring_cur = '0;
  logic signed [7:0] cm = '0;
  logic [15:0] mdl [64];
  logic [11:0] gains [5];
  int err_total = 0, samples_checked = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  lgt_line_regs lgt_line_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_sample_in(rx_in), .rx_sample_in_valid(rx_iv), .rx_sample_out(rx_out),
    .rx_sample_out_valid(rx_ov), .tx_sample_in(tx_in), .tx_sample_in_valid(tx_iv), .tx_sample_out(tx_out),
    .tx_sample_out_valid(tx_ov), .loop_current_code(loop_cur), .ringing_active(ringing),
    .ring_current_code(ring_cur), .cm_voltage_code(cm), .loop_closed(loop_closed), .ring_trip(ring_trip),
    .wide_bandwidth(wide_bandwidth));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic unm(input logic [5:0] i);
    return !((i >= 6'h1a && i <= 6'h2b) || i == 6'h30 || i == 6'h31);
  endfunction
  function automatic logic signed [15:0] sat(input logic signed [15:0] x, input logic [11:0] g);
    longint p;
    p = (longint'(x) * longint'($signed(g))) >>> 10;
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    return 16'(p);
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Answer is taken at the edge that samples pready high, before that edge's own updates land
  task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] i, input logic [15:0] d, input logic [3:0] s = 4'hf);
    seed = lfsr(seed);
    apb(1'b1, i, {seed[15:0], d}, s);
    if (!unm(i) && i != 6'h2a && i != 6'h31)
    begin
      if (s[0]) mdl[i][7:0] = d[7:0];
      if (s[1]) mdl[i][15:8] = d[15:8];
    end
    chk("write error", 32'(unm(i)), 32'(er));
  endtask
  task automatic rdchk(input logic [5:0] i, input logic [31:0] exp);
    apb(1'b0, i, 32'h0, 4'h0);
    chk("read data", exp, rd);
    chk("read error", 32'(unm(i)), 32'(er));
  endtask
  task automatic det(input logic [5:0] lc, input logic rg, input logic [5:0] rc, input logic signed [7:0] c,
                     input logic [2:0] e);
    @(posedge pclk);
    loop_cur <= lc;
    ringing <= rg;
    ring_cur <= rc;
    cm <= c;
    repeat (2) @(posedge pclk);
    #1;
    chk("detectors", 32'(e), 32'({wide_bandwidth, ring_trip, loop_closed}));
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_total++;
      close_out();
    end
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    for (int i = 0; i < 64; i++) mdl[i] = '0;
    gains = '{12'h000, 12'h400, 12'h7ff, 12'hc00, 12'h2a5};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 'h1a; i <= 'h2b; i++) rdchk(6'(i), 32'h0);
    $display("reset values done");
    for (int i = 'h1a; i <= 'h2b; i++)
    begin
      seed = lfsr(seed);
      wr(6'(i), seed[15:0]);
    end
    for (int i = 'h1a; i <= 'h2b; i++) rdchk(6'(i), (i == 'h2a) ? 32'h0 : 32'(mdl[i]));
    wr(lgt_pkg::IDX_CM_HIGH, 16'h5a5a, 4'h1);
    rdchk(lgt_pkg::IDX_CM_HIGH, 32'(mdl[lgt_pkg::IDX_CM_HIGH]));
    wr(6'h3f, 16'h1234);
    rdchk(6'h3f, 32'h0);
    $display("register access done");
    for (int g = 0; g < 5; g++)
    begin
      seed = lfsr(seed);
      smp = '{16'sh7fff, 16'sh8000, seed[15:0]};
      wr(lgt_pkg::IDX_RECEIVE_GAIN, {gains[g], 4'h0});
      wr(lgt_pkg::IDX_TRANSMIT_GAIN, {~gains[g], 4'h0});
      for (int k = 0; k < 3; k++)
      begin
        @(posedge pclk);
        rx_in <= smp[k];
        tx_in <= smp[k];
        rx_iv <= 1'b1;
        tx_iv <= 1'b1;
        @(posedge pclk);
        rx_iv <= 1'b0;
        tx_iv <= 1'b0;
        #1;
        chk("rx sample", 32'({1'b1, sat(smp[k], gains[g])}), 32'({rx_ov, rx_out}));
        chk("tx sample", 32'({1'b1, sat(smp[k], ~gains[g])}), 32'({tx_ov, tx_out}));
      end
    end
    $display("gain paths done");
    wr(lgt_pkg::IDX_LOOP_UPPER, 16'h2800);
    wr(lgt_pkg::IDX_LOOP_LOWER, 16'h2800);
    wr(lgt_pkg::IDX_RING_TRIP, 16'h0f00);
    wr(lgt_pkg::IDX_CM_LOW, 16'h0100);
    wr(lgt_pkg::IDX_CM_HIGH, 16'h0180);
    wr(lgt_pkg::IDX_HYST_CTRL, 16'h0000);
    det(6'd21, 1'b0, 6'd63, 8'sd0, 3'b001);
    det(6'd20, 1'b1, 6'd31, -8'sd9, 3'b110);
    rdchk(lgt_pkg::IDX_DETECT_STATUS, 32'h6);
    det(6'd15, 1'b1, 6'd30, -8'sd8, 3'b000);
    det(6'd0, 1'b0, 6'd0, 8'sd13, 3'b100);
    det(6'd0, 1'b0, 6'd0, 8'sd12, 3'b000);
    wr(lgt_pkg::IDX_HYST_CTRL, 16'h0001);
    rdchk(lgt_pkg::IDX_HYST_CTRL, 32'h1);
    det(6'd21, 1'b0, 6'd0, 8'sd0, 3'b001);
    det(6'd15, 1'b0, 6'd0, 8'sd0, 3'b001);
    det(6'd9, 1'b0, 6'd0, 8'sd0, 3'b000);
    det(6'd15, 1'b0, 6'd0, 8'sd0, 3'b000);
    $display("detectors done");
    close_out();
  end
endmodule // lgt_line_regs_tb_top

bind lgt_line_regs lgt_line_regs_monitor #(.SAMPLE_W(SAMPLE_W), .CM_W(CM_W)) lgt_line_regs_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_sample_in(rx_sample_in), .rx_sample_in_valid(rx_sample_in_valid), .rx_sample_out(rx_sample_out),
  .rx_sample_out_valid(rx_sample_out_valid), .tx_sample_in(tx_sample_in), .tx_sample_in_valid(tx_sample_in_valid),
  .tx_sample_out(tx_sample_out), .tx_sample_out_valid(tx_sample_out_valid), .loop_current_code(loop_current_code),
  .ringing_active(ringing_active), .ring_current_code(ring_current_code), .cm_voltage_code(cm_voltage_code),
  .loop_closed(loop_closed), .ring_trip(ring_trip), .wide_bandwidth(wide_bandwidth));
